//--- pkg/idepm_defs.svh
/*
  Address decode constants and strap/reset timing for the IDE decode and
  pin-sharing block. Assumes inclusion by the package and the design files.
*/
`ifndef IDEPM_DEFS_SVH
`define IDEPM_DEFS_SVH

`define IDEPM_ADDR_W 10
`define IDEPM_PRI_CMD_BASE 10'h1F0
`define IDEPM_SEC_CMD_BASE 10'h170
`define IDEPM_PRI_CTL_BASE 10'h3F6
`define IDEPM_SEC_CTL_BASE 10'h376
`define IDEPM_COMB_EXTRA 10'h2F7
`define IDEPM_CMD_MASK 10'h3F8
`define IDEPM_CTL_MASK 10'h3FE
`define IDEPM_CFG_GIO_BIT 2
`define IDEPM_DIR_POL_BIT 5
`define IDEPM_SYNC_W 2

`endif

//--- pkg/idepm_pkg.sv
/*
  Types for the IDE decode and pin-sharing block.
  Assumes idepm_defs.svh is on the include path.
*/
`include "idepm_defs.svh"

package idepm_pkg;

  typedef logic [`IDEPM_ADDR_W-1:0] idepm_addr_t;

  typedef enum logic [1:0]
  {
    IDEPM_ST_RESET = 2'h0,
    IDEPM_ST_CATCH = 2'h1,
    IDEPM_ST_RUN = 2'h2,
    IDEPM_ST_WAIT = 2'h3
  } idepm_state_e;

  typedef struct packed
  {
    idepm_state_e state;
    logic addr_sel;
    logic ide_dis;
    logic gio_sel;
    logic uart_sel;
    logic fdc_dis;
  } idepm_st_s;

endpackage

//--- rtl/idepm_sync.sv
/*
  Two-flip-flop synchroniser bank for pin-level inputs.
  Assumes inputs are asynchronous levels; output is in i_core_clk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module idepm_sync
  import idepm_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic [W-1:0] i_async, // Asynchronous levels
  output logic [W-1:0] o_sync // Synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

`default_nettype wire

//--- rtl/idepm_top.sv
/*
  IDE address decode, power-on strap capture and shared-pin muxing.
  Assumes the host bus address/strobes arrive as asynchronous pins and
  that configuration bits come from a configuration block on i_core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "idepm_defs.svh"

// Contract
// RL1 - Primary select for 1F0-1F7 or 170-177
// RL2 - Secondary select for 3F6-3F7 or 376-377
// RL3 - Address strap sampled at reset, high primary
// RL4 - IDE enable strap on primary select, low enables
// RL5 - Low-byte enable over command and control ranges
// RL6 - High-byte enable needs sixteen-bit indication, command range
// RL7 - Combined enable low for 1F0-1F7 and 2F7
// RL8 - GPIO strap picks combined/GPIO or byte-enable pins
// RL9 - Config bit 2 overrides GPIO pin selection
// RL10 - UART/infrared strap picks second serial port mode
// RL11 - Floppy strap, low enables floppy port
// RL12 - Parallel direction: 0 write, 1 read; inverted here when direction config bit 5 is set
// RL13 - Config reassigns four pins to infrared functions
// RL14 - Active-low IDE reset output to drive
// RL15 - Straps latched at reset release, then held
module idepm_top
  import idepm_pkg::*;
(
  input wire logic i_core_clk, // Core clock, 100 MHz
  input wire logic i_rst_b, // Power-on reset, async, active low
  input wire logic [`IDEPM_ADDR_W-1:0] i_host_addr, // Host I/O address pins
  input wire logic i_host_io_b, // Host I/O read or write strobe, low
  input wire logic i_aen, // Host DMA address enable, high blocks
  input wire logic i_sixteen_bit_io_indication_b, // Drive 16-bit I/O, low
  input wire logic i_ide_reset_req, // Request to hold drive in reset
  input wire logic i_parallel_read, // Parallel port is reading
  input wire logic [7:0] i_parallel_direction_config_register, // Dir cfg
  input wire logic [7:0] i_gpio_config_register, // GPIO/IDE select cfg
  input wire logic i_gpio_cfg_override, // Config bit 2 written by software
  input wire logic [3:0] i_infrared_pin_config_register, // IR pin enables
  input wire logic i_infrared_transmit_two, // IR transmit 2 data
  input wire logic i_infrared_transmit_three, // IR transmit 3 data
  input wire logic i_general_io_zero_out, // GPIO 0 output value
  input wire logic i_general_io_zero_oe, // GPIO 0 output enable
  input wire logic i_general_io_one_out, // GPIO 1 output value
  input wire logic i_general_io_one_oe, // GPIO 1 output enable
  input wire logic i_ide_data_bit_seven_out, // IDE data 7 output value
  input wire logic i_ide_data_bit_seven_oe, // IDE data 7 output enable
  input wire logic i_pin1_in, // Pad 1: reset / IR receive 3
  input wire logic i_pin2_in, // Pad 2: direction / floppy strap
  input wire logic i_pin91_in, // Pad 91: low enable / GPIO strap
  input wire logic i_pin92_in, // Pad 92: high enable / UART strap
  input wire logic i_pin94_in, // Pad 94: primary select / IDE strap
  input wire logic i_pin95_in, // Pad 95: secondary select / addr strap
  input wire logic i_pin96_in, // Pad 96: IDE data 7 / GPIO 1
  output logic o_pin1_out, // Pad 1 value
  output logic o_pin1_oe, // Pad 1 drive enable
  output logic o_pin2_out, // Pad 2 value
  output logic o_pin2_oe, // Pad 2 drive enable
  output logic o_pin91_out, // Pad 91 value
  output logic o_pin91_oe, // Pad 91 drive enable
  output logic o_pin92_out, // Pad 92 value
  output logic o_pin92_oe, // Pad 92 drive enable
  output logic o_pin94_out, // Pad 94 value
  output logic o_pin94_oe, // Pad 94 drive enable
  output logic o_pin95_out, // Pad 95 value
  output logic o_pin95_oe, // Pad 95 drive enable
  output logic o_pin96_out, // Pad 96 value
  output logic o_pin96_oe, // Pad 96 drive enable
  output logic o_infrared_receive_three, // IR receive 3 from pad 1
  output logic o_infrared_receive_four, // IR receive 4 from pad 94
  output logic o_general_io_zero_in, // GPIO 0 level from pad 92
  output logic o_general_io_one_in, // GPIO 1 level from pad 96
  output logic o_ide_data_bit_seven_in, // IDE data 7 level from pad 96
  output logic o_ide_enabled, // Latched: IDE function enabled
  output logic o_floppy_enabled, // Latched: floppy port enabled
  output logic o_second_serial_port_uart, // Latched: 1 UART, 0 infrared
  output logic o_ide_secondary_range, // Latched: secondary ranges in use
  output logic o_gpio_pins_active, // GPIO pin set in effect
  output logic o_straps_valid // Straps captured, pins in normal use
);

  // ==========================================================
  // Synchronisers for pins
  // ==========================================================
  localparam int SW = `IDEPM_ADDR_W + 10;
  logic [SW-1:0] raw_w;
  logic [SW-1:0] syn_w;

  assign raw_w = {i_host_addr, i_host_io_b, i_aen,
                  i_sixteen_bit_io_indication_b, i_pin1_in, i_pin2_in,
                  i_pin91_in, i_pin92_in, i_pin94_in, i_pin95_in,
                  i_pin96_in};

  idepm_sync #(.W(SW)) u_sync
  (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(raw_w),
    .o_sync(syn_w)
  );

  idepm_addr_t addr_s;
  logic io_b_s, aen_s, cs16_b_s;
  logic p1_s, p2_s, p91_s, p92_s, p94_s, p95_s, p96_s;
  assign {addr_s, io_b_s, aen_s, cs16_b_s, p1_s, p2_s, p91_s, p92_s,
          p94_s, p95_s, p96_s} = syn_w;

  // ==========================================================
  // Decode functions
  // ==========================================================
  function automatic logic in_cmd(input idepm_addr_t a, input logic sec);
    in_cmd = (a & `IDEPM_CMD_MASK) ==
             (sec ? `IDEPM_SEC_CMD_BASE : `IDEPM_PRI_CMD_BASE);
  endfunction

  function automatic logic in_ctl(input idepm_addr_t a, input logic sec);
    in_ctl = (a & `IDEPM_CTL_MASK) ==
             (sec ? `IDEPM_SEC_CTL_BASE : `IDEPM_PRI_CTL_BASE);
  endfunction

  // ==========================================================
  // State: strap capture and decoded selects
  // ==========================================================
  idepm_st_s st_r, st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r.state)
      IDEPM_ST_RESET:
      begin
        // Synchroniser still holds its reset zeros here
        st_nxt.state = IDEPM_ST_WAIT;
      end
      IDEPM_ST_WAIT:
      begin
        // Pads through the first flop only; both flops hold them in CATCH
        st_nxt.state = IDEPM_ST_CATCH;
      end
      IDEPM_ST_CATCH:
      begin
        st_nxt.addr_sel = p95_s; // see RL3
        st_nxt.ide_dis = p94_s; // see RL4
        st_nxt.gio_sel = p91_s; // see RL8
        st_nxt.uart_sel = p92_s; // see RL10
        st_nxt.fdc_dis = p2_s; // see RL11
        st_nxt.state = IDEPM_ST_RUN; // see RL15
      end
      IDEPM_ST_RUN:
      begin
        st_nxt.state = IDEPM_ST_RUN;
      end
      default:
      begin
        st_nxt.state = IDEPM_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_r <= '{state: IDEPM_ST_RESET, addr_sel: 1'b1, ide_dis: 1'b0,
                gio_sel: 1'b0, uart_sel: 1'b1, fdc_dis: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Address decode
  // ==========================================================
  logic run_w, sec_w, cyc_w, ide_on_w, gio_w;
  logic pri_sel_w, sec_sel_w, lo_en_w, hi_en_w, comb_en_w;
  logic ir_rx3_w, ir_tx2_w, ir_tx3_w, ir_rx4_w, dir_w;

  assign run_w = (st_r.state == IDEPM_ST_RUN);
  assign sec_w = !st_r.addr_sel;
  assign cyc_w = run_w && !io_b_s && !aen_s;
  assign ide_on_w = cyc_w && !st_r.ide_dis;
  assign pri_sel_w = ide_on_w && in_cmd(addr_s, sec_w); // see RL1
  assign sec_sel_w = ide_on_w && in_ctl(addr_s, sec_w); // see RL2
  assign lo_en_w = pri_sel_w || sec_sel_w; // see RL5
  assign hi_en_w = pri_sel_w && !cs16_b_s; // see RL6
  assign comb_en_w = ide_on_w && (in_cmd(addr_s, 1'b0) ||
                     addr_s == `IDEPM_COMB_EXTRA); // see RL7
  // Software bit overrides the strap once asked to
  assign gio_w = i_gpio_cfg_override ?
                 i_gpio_config_register[`IDEPM_CFG_GIO_BIT] :
                 st_r.gio_sel; // see RL9
  assign ir_rx3_w = i_infrared_pin_config_register[0];
  assign ir_tx2_w = i_infrared_pin_config_register[1];
  assign ir_tx3_w = i_infrared_pin_config_register[2];
  assign ir_rx4_w = i_infrared_pin_config_register[3];
  assign dir_w = i_parallel_direction_config_register[`IDEPM_DIR_POL_BIT] ?
                 !i_parallel_read : i_parallel_read; // see RL12

  // ==========================================================
  // Pin multiplexing (pads released until straps are held)
  // ==========================================================
  always_comb
  begin
    o_pin1_out = !i_ide_reset_req; // see RL14
    o_pin1_oe = run_w && !ir_rx3_w; // see RL13
    o_pin2_out = ir_tx2_w ? i_infrared_transmit_two : dir_w; // see RL13
    o_pin2_oe = run_w;
    o_pin94_out = !pri_sel_w;
    o_pin94_oe = run_w && !ir_rx4_w; // see RL13
    o_pin95_out = ir_tx3_w ? i_infrared_transmit_three : !sec_sel_w; // see RL13
    o_pin95_oe = run_w;
    o_pin91_out = gio_w ? !comb_en_w : !lo_en_w; // see RL8
    o_pin91_oe = run_w;
    o_pin92_out = gio_w ? i_general_io_zero_out : !hi_en_w;
    o_pin92_oe = run_w && (gio_w ? i_general_io_zero_oe : 1'b1);
    o_pin96_out = gio_w ? i_general_io_one_out : i_ide_data_bit_seven_out;
    o_pin96_oe = run_w && (gio_w ? i_general_io_one_oe :
                 i_ide_data_bit_seven_oe);
  end

  assign o_infrared_receive_three = ir_rx3_w ? p1_s : 1'b1;
  assign o_infrared_receive_four = ir_rx4_w ? p94_s : 1'b1;
  assign o_general_io_zero_in = p92_s;
  assign o_general_io_one_in = p96_s;
  assign o_ide_data_bit_seven_in = p96_s;
  assign o_ide_enabled = !st_r.ide_dis;
  assign o_floppy_enabled = !st_r.fdc_dis;
  assign o_second_serial_port_uart = st_r.uart_sel;
  assign o_ide_secondary_range = sec_w;
  assign o_gpio_pins_active = gio_w;
  assign o_straps_valid = run_w;

endmodule

`default_nettype wire

//--- bench/idepm_props.sv
/* Port checker for idepm_top.
   Assumes bind to idepm_top and host pins held for 3 cycles. */
`timescale 1ns/100ps
`default_nettype none
`include "idepm_defs.svh"
module idepm_props
(
  input wire logic i_core_clk, // Clock
  input wire logic i_rst_b, // Reset
  input wire logic [`IDEPM_ADDR_W-1:0] i_host_addr, // Address
  input wire logic i_host_io_b, // Strobe
  input wire logic i_aen, // DMA
  input wire logic i_sixteen_bit_io_indication_b, // 16-bit
  input wire logic [3:0] i_infrared_pin_config_register, // IR cfg
  input wire logic o_pin91_out, // Pad 91
  input wire logic o_pin92_out, // Pad 92
  input wire logic o_pin94_out, // Pad 94
  input wire logic o_pin94_oe, // Pad 94 enable
  input wire logic o_pin95_out, // Pad 95
  input wire logic o_ide_enabled, // IDE on
  input wire logic o_ide_secondary_range, // Secondary
  input wire logic o_gpio_pins_active, // GPIO set
  input wire logic o_straps_valid // Straps held
);
  // ==========
  // Decode and properties
  wire logic sec = o_ide_secondary_range;
  wire logic cmd = (i_host_addr & `IDEPM_CMD_MASK) ==
    (sec ? `IDEPM_SEC_CMD_BASE : `IDEPM_PRI_CMD_BASE);
  wire logic ctl = (i_host_addr & `IDEPM_CTL_MASK) ==
    (sec ? `IDEPM_SEC_CTL_BASE : `IDEPM_PRI_CTL_BASE);
  wire logic comb = (i_host_addr & `IDEPM_CMD_MASK) ==
    `IDEPM_PRI_CMD_BASE || i_host_addr == `IDEPM_COMB_EXTRA;
  wire logic ir_off = i_infrared_pin_config_register == 4'h0;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_held;
    $stable(i_host_addr) && $stable(i_sixteen_bit_io_indication_b) &&
      !i_host_io_b && !i_aen && o_straps_valid && o_ide_enabled && ir_off;
  endsequence
  property p_pri; s_held [*3] |-> o_pin94_out == !cmd; endproperty
  a_pri: assert property (p_pri) else $error("primary select");
  property p_sec; s_held [*3] |-> o_pin95_out == !ctl; endproperty
  a_sec: assert property (p_sec) else $error("secondary select");
  property p_lo;
    s_held [*3] ##0 !o_gpio_pins_active |-> o_pin91_out == !(cmd || ctl);
  endproperty
  a_lo: assert property (p_lo) else $error("low enable");
  property p_comb;
    s_held [*3] ##0 o_gpio_pins_active |-> o_pin91_out == !comb;
  endproperty
  a_comb: assert property (p_comb) else $error("combined enable");
  property p_hi;
    s_held [*3] ##0 !o_gpio_pins_active |->
      o_pin92_out == !(cmd && !i_sixteen_bit_io_indication_b);
  endproperty
  a_hi: assert property (p_hi) else $error("high enable");
  property p_idle;
    (i_aen && o_straps_valid && ir_off) [*3] |-> o_pin94_out && o_pin95_out;
  endproperty
  a_idle: assert property (p_idle) else $error("select in DMA");
  property p_hold;
    o_straps_valid && $past(o_straps_valid) |->
      $stable({o_ide_enabled, o_ide_secondary_range});
  endproperty
  a_hold: assert property (p_hold) else $error("strap moved");
  property p_oe_off; !o_straps_valid |-> !o_pin94_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("early drive");
endmodule
bind idepm_top idepm_props idepm_props_i (.*);
`default_nettype wire

//--- bench/idepm_pads.sv
/* Pad model for the strapped shared pins.
   Bit order: pin95, pin94, pin91, pin92, pin2. */
`timescale 1ns/100ps
`default_nettype none
module idepm_pads
(
  input wire logic [4:0] i_strap, // Strap resistors
  input wire logic [4:0] i_out, // Pad values
  input wire logic [4:0] i_oe, // Pad enables
  output logic [4:0] o_pad // Pad levels
);
  // ==========
  // Undriven pads rest at the strap resistor level
  assign o_pad = (i_oe & i_out) |
    (~i_oe & i_strap);
endmodule
`default_nettype wire

//--- bench/idepm_top_test.sv
/* Self-checking bench for idepm_top.
   Assumes the pad model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "idepm_defs.svh"
module idepm_top_test;
  logic i_core_clk, i_rst_b, i_host_io_b, i_aen, i_ide_reset_req;
  logic i_sixteen_bit_io_indication_b, i_parallel_read, i_gpio_cfg_override;
  logic [9:0] i_host_addr;
  logic [7:0] i_parallel_direction_config_register, i_gpio_config_register;
  logic [3:0] i_infrared_pin_config_register;
  logic i_infrared_transmit_two, i_infrared_transmit_three, i_pin1_in;
  logic i_general_io_zero_out, i_general_io_zero_oe, i_general_io_one_out;
  logic i_general_io_one_oe, i_ide_data_bit_seven_out, i_pin96_in;
  logic i_ide_data_bit_seven_oe, i_pin2_in, i_pin91_in, i_pin92_in;
  logic i_pin94_in, i_pin95_in, o_pin1_out, o_pin1_oe, o_pin2_out, o_pin2_oe;
  logic o_pin91_out, o_pin91_oe, o_pin92_out, o_pin92_oe, o_pin94_out;
  logic o_pin94_oe, o_pin95_out, o_pin95_oe, o_pin96_out, o_pin96_oe;
  logic o_infrared_receive_three, o_infrared_receive_four, o_straps_valid;
  logic o_general_io_zero_in, o_general_io_one_in, o_ide_data_bit_seven_in;
  logic o_ide_enabled, o_floppy_enabled, o_second_serial_port_uart;
  logic o_ide_secondary_range, o_gpio_pins_active, eg, es, ee;
  logic [4:0] strap, pad;
  logic [9:0] adr [8] = '{10'h1F0, 10'h1F7, 10'h1F8, 10'h3F6, 10'h3F7,
    10'h3F5, 10'h170, 10'h2F7};
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  idepm_top idepm_top_i (.*);
  idepm_pads idepm_pads_i
  (
    .i_strap(strap),
    .i_out({o_pin95_out, o_pin94_out, o_pin91_out, o_pin92_out, o_pin2_out}),
    .i_oe({o_pin95_oe, o_pin94_oe, o_pin91_oe, o_pin92_oe, o_pin2_oe}),
    .o_pad(pad)
  );
  assign {i_pin95_in, i_pin94_in, i_pin91_in, i_pin92_in, i_pin2_in} = pad;
  // ==========
  // Clock, timeout and tasks
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  task finish_test();
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic s, input logic e);
    checked = checked + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task por(input logic [4:0] st);
    strap = st;
    i_rst_b = 1'b0;
    wt(12);
    i_rst_b = 1'b1;
    wt(4);
  endtask
  task acc(input logic [9:0] ad, input logic sx);
    logic c, k, m;
    c = ee && (ad & `IDEPM_CMD_MASK) ==
      (es ? `IDEPM_SEC_CMD_BASE : `IDEPM_PRI_CMD_BASE);
    k = ee && (ad & `IDEPM_CTL_MASK) ==
      (es ? `IDEPM_SEC_CTL_BASE : `IDEPM_PRI_CTL_BASE);
    m = ee && ((ad & `IDEPM_CMD_MASK) == `IDEPM_PRI_CMD_BASE ||
      ad == `IDEPM_COMB_EXTRA);
    {i_host_addr, i_sixteen_bit_io_indication_b, i_host_io_b} = {ad, sx, 1'b0};
    wt(3);
    chk("pin94", o_pin94_out, !c);
    chk("pin95", o_pin95_out, !k);
    chk("pin91", o_pin91_out, eg ? !m : !(c || k));
    if (!eg)
      chk("pin92", o_pin92_out, !(c && !sx));
    i_host_io_b = 1'b1;
    wt(1);
  endtask
  // ==========
  // Test sequence
  initial
  begin
    {i_host_addr, i_aen, i_sixteen_bit_io_indication_b, i_ide_reset_req,
      i_parallel_read, i_parallel_direction_config_register, i_pin96_in,
      i_gpio_config_register, i_gpio_cfg_override, i_pin1_in,
      i_infrared_pin_config_register, i_infrared_transmit_two,
      i_infrared_transmit_three, i_general_io_zero_out,
      i_general_io_zero_oe, i_core_clk, i_rst_b} = '0;
    {i_host_io_b, i_general_io_one_out, i_general_io_one_oe,
      i_ide_data_bit_seven_oe, i_ide_data_bit_seven_out} = 5'h1E;
    {eg, es, ee} = 3'h1;
    por(5'h12);
    chk("ide_en", o_ide_enabled, 1'b1);
    chk("fdc_en", o_floppy_enabled, 1'b1);
    chk("uart", o_second_serial_port_uart, 1'b1);
    chk("sec", o_ide_secondary_range, 1'b0);
    chk("gio", o_gpio_pins_active, 1'b0);
    chk("oe", o_pin1_oe & o_pin2_oe & o_pin91_oe & o_pin95_oe, 1'b1);
    chk("pin96", o_pin96_out, 1'b0);
    chk("pin1", o_pin1_out, 1'b1);
    foreach (adr[n])
      acc(adr[n], n[0]);
    {i_aen, ee} = 2'h2;
    acc(10'h1F0, 1'b0);
    {i_aen, ee} = 2'h1;
    for (int j = 0; j < 4; j++)
    begin
      {i_parallel_direction_config_register[5], i_parallel_read} = j[1:0];
      wt(3);
      chk("pin2", o_pin2_out, j[0] ^ j[1]);
    end
    i_ide_reset_req = 1'b1;
    wt(3);
    chk("pin1", o_pin1_out, 1'b0);
    i_ide_reset_req = 1'b0;
    i_infrared_pin_config_register = 4'hF;
    for (int j = 0; j < 2; j++)
    begin
      {i_pin1_in, i_infrared_transmit_two, i_infrared_transmit_three,
        i_pin96_in, strap[3]} = {5{j[0]}};
      wt(3);
      chk("rx3", o_infrared_receive_three, j[0]);
      chk("tx2", o_pin2_out, j[0]);
      chk("tx3", o_pin95_out, j[0]);
      chk("rx4", o_infrared_receive_four, j[0]);
      chk("pin1_oe", o_pin1_oe, 1'b0);
      chk("general_io_one_in", o_general_io_one_in, j[0]);
      chk("d7_in", o_ide_data_bit_seven_in, j[0]);
    end
    i_infrared_pin_config_register = 4'h0;
    {i_gpio_cfg_override, i_gpio_config_register} = 9'h104;
    strap[1] = 1'b0;
    wt(3);
    eg = 1'b1;
    chk("gio", o_gpio_pins_active, 1'b1);
    chk("pin96", o_pin96_out, 1'b1);
    chk("pin92_oe", o_pin92_oe, 1'b0);
    chk("general_io_zero_in", o_general_io_zero_in, 1'b0);
    acc(10'h2F7, 1'b0);
    {i_gpio_cfg_override, i_gpio_config_register} = 9'h000;
    {eg, es, ee} = 3'h7;
    por(5'h05);
    chk("sec", o_ide_secondary_range, 1'b1);
    chk("fdc_en", o_floppy_enabled, 1'b0);
    chk("uart", o_second_serial_port_uart, 1'b0);
    foreach (adr[n])
      acc(adr[n], 1'b0);
    strap = 5'h12;
    wt(4);
    chk("hold", o_ide_secondary_range, 1'b1);
    i_gpio_cfg_override = 1'b1;
    wt(3);
    eg = 1'b0;
    chk("gio", o_gpio_pins_active, 1'b0);
    acc(10'h376, 1'b0);
    acc(10'h170, 1'b0);
    acc(10'h1F0, 1'b0);
    por(5'h1A);
    chk("ide_en", o_ide_enabled, 1'b0);
    ee = 1'b0;
    acc(10'h1F0, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
